/* gpio_blk_pkg.sv */
// Constants for the buffered output-control block of one 16-bit port.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package gpio_blk_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Port geometry.
  localparam int PORT_W = 16;
  localparam int BLK_W = 8;
  localparam int NUM_BLK = 2;
  localparam int SYNC_STAGES = 2;

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_BIT = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_FLAG = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;

  ////////////////////////////////////////////////////////////////////////
  // Field positions of the bit-addressed write words.
  localparam int BIT_IDX_LSB = 0;
  localparam int BIT_IDX_W = 4;
  localparam int BIT_VAL_POS = 8;
  localparam logic [3:0] CTRL_ARM_IDX = 4'h0;
  localparam logic [3:0] CTRL_FIRE_IDX = 4'hf;
  localparam int FLAG_SWRST_POS = 15;

  ////////////////////////////////////////////////////////////////////////
  // Status word field positions.
  localparam int STAT_OE_LO = 0;
  localparam int STAT_OE_HI = 1;
  localparam int STAT_ARM = 2;
  localparam int STAT_STRAP = 3;
  localparam int STAT_INV_LO = 4;
  localparam int STAT_INV_HI = 5;

  ////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [15:0] RST_FLAG = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

endpackage : gpio_blk_pkg

/* pin_sync.sv */
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes every bit is a slow level; no bit is read between the stages.
`timescale 1ns/100ps

module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Levels in and out.
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] stage1;

  // The first stage feeds only the second, so metastability settles there.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule : pin_sync

/* gpio_blk_ctrl.sv */
// Output-enable and output-latch control for one 16-bit buffered port.
// Assumes a classic Wishbone master on i_ref_clk and pins, straps and
// polarity selects that arrive asynchronously from the board.
//
// Operation
// (RQ1) Port is two 8-bit blocks, own enables.
// (RQ2) Non-inverting block resets to driving zeros.
// (RQ3) Non-inverting: written one drives pin high.
// (RQ4) Inverting block resets to driving ones.
// (RQ5) Inverting: written one drives pin low.
// (RQ6) Hardware reset returns every block to input.
// (RQ7) Disabled block leaves its pins undriven.
// (RQ8) Any bit write enables the whole block.
// (RQ9) Host should first write whole bytes or words.
// (RQ10) Later bit writes leave other bits unchanged.
// (RQ11) Enable stays until hardware or software reset.
// (RQ12) Software reset: one to bit 0, then 15.
// (RQ13) Written value stays latched until reset or rewrite.
// (RQ14) Software reset also clears flag bit 15.
// (RQ15) Output-disable strap keeps the port input-only.
// (RQ16) Reads return live pin levels always.
// (RQ17) Static polarity input per block sets mapping.
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps

module gpio_blk_ctrl (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Wishbone slave.
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Board straps.
  input wire logic i_output_disable_strap,
  input wire logic [1:0] i_invert_sel,
  // Port pins.
  input wire logic [15:0] i_pin_in,
  output logic [15:0] o_pin_out,
  output logic [15:0] o_pin_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Synchronised board inputs.

  logic [15:0] pin_s;
  logic strap_s;
  logic [1:0] inv_s;

  // Pins and straps come from outside the clock domain.
  pin_sync #(.W(19)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_async({i_output_disable_strap, i_invert_sel, i_pin_in}),
    .o_sync({strap_s, inv_s, pin_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic wr;
  logic rd;
  logic data_wr;
  logic bit_wr;
  logic ctrl_wr;
  logic flag_wr;
  logic [3:0] idx;
  logic val;
  logic sw_fire;
  logic reset_arm;
  logic [15:0] flag;
  logic [15:0] latch;
  logic [1:0] blk_oe;

  // A request is served once, in the cycle before the ack appears.
  assign wr = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
  assign rd = i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack;
  assign data_wr = wr && (i_wb_adr == gpio_blk_pkg::OFS_DATA);
  assign bit_wr = wr && (i_wb_adr == gpio_blk_pkg::OFS_BIT);
  assign ctrl_wr = wr && (i_wb_adr == gpio_blk_pkg::OFS_CTRL);
  assign flag_wr = wr && (i_wb_adr == gpio_blk_pkg::OFS_FLAG);
  assign idx = i_wb_dat[gpio_blk_pkg::BIT_IDX_LSB +: gpio_blk_pkg::BIT_IDX_W];
  assign val = i_wb_dat[gpio_blk_pkg::BIT_VAL_POS];

  // The reset fires only on a write to bit 15 after bit 0 was armed.
  assign sw_fire = ctrl_wr && reset_arm && (idx == gpio_blk_pkg::CTRL_FIRE_IDX); // [RQ12]

  ////////////////////////////////////////////////////////////////////////
  // Software reset arm.

  // Writing one to control bit 0 arms; zero or a completed reset disarms.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      reset_arm <= 1'b0;
    end else if (sw_fire) begin
      reset_arm <= 1'b0; // [RQ12]
    end else if (ctrl_wr && idx == gpio_blk_pkg::CTRL_ARM_IDX) begin
      reset_arm <= val; // [RQ12]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flag word.

  // Bit 15 drops on a software reset so the host can see it took effect.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flag <= gpio_blk_pkg::RST_FLAG;
    end else if (sw_fire) begin
      flag[gpio_blk_pkg::FLAG_SWRST_POS] <= 1'b0; // [RQ14]
    end else if (flag_wr) begin
      if (i_wb_sel[0]) begin
        flag[7:0] <= i_wb_dat[7:0];
      end
      if (i_wb_sel[1]) begin
        flag[15:8] <= i_wb_dat[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-block latch and output enable.

  genvar b;
  generate
    for (b = 0; b < gpio_blk_pkg::NUM_BLK; b++) begin : g_blk
      logic oe;
      logic [7:0] lat;
      logic byte_wr;
      logic one_wr;

      // A byte lane or a single bit that lands in this block.
      assign byte_wr = data_wr && i_wb_sel[b]; // [RQ1]
      assign one_wr = bit_wr && (idx[3] == 1'(b)); // [RQ1]

      // The latch holds pre-polarity data; zero after any reset.
      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          lat <= gpio_blk_pkg::RST_LATCH; // [RQ2] [RQ4]
        end else if (sw_fire) begin
          lat <= gpio_blk_pkg::RST_LATCH; // [RQ2] [RQ4]
        end else if (byte_wr) begin
          lat <= i_wb_dat[b*8 +: 8]; // [RQ13]
        end else if (one_wr) begin
          lat[idx[2:0]] <= val; // [RQ10]
        end
      end

      // Any write to the block enables all eight bits; only resets clear it.
      // The strap blocks the set, so a strapped port never drives.
      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          oe <= 1'b0; // [RQ6]
        end else if (sw_fire) begin
          oe <= 1'b0; // [RQ12]
        end else if ((byte_wr || one_wr) && !strap_s) begin
          oe <= 1'b1; // [RQ8] [RQ11] [RQ15]
        end
      end

      assign latch[b*8 +: 8] = lat;
      assign blk_oe[b] = oe;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers.

  logic [15:0] next_pin_out;
  logic [15:0] next_pin_oe;

  // Polarity applies per block; the strap also drops a live enable.
  always_comb begin
    next_pin_out = latch ^ {{8{inv_s[1]}}, {8{inv_s[0]}}}; // [RQ3] [RQ5] [RQ17]
    next_pin_oe = {{8{blk_oe[1]}}, {8{blk_oe[0]}}}; // [RQ8]
    if (strap_s) begin
      next_pin_oe = '0; // [RQ15]
    end
  end

  // Registered so pins see clean edges; the drive lags the latch one cycle.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pin_out <= '0;
      o_pin_oe <= '0; // [RQ6] [RQ7]
    end else begin
      o_pin_out <= next_pin_out;
      o_pin_oe <= next_pin_oe; // [RQ7]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux and acknowledge.

  logic [31:0] next_rdata;

  // Unmapped offsets read zero and are still acknowledged.
  always_comb begin
    next_rdata = gpio_blk_pkg::RST_RDATA;
    case (i_wb_adr)
      gpio_blk_pkg::OFS_DATA: begin
        next_rdata[15:0] = pin_s; // [RQ16]
      end
      gpio_blk_pkg::OFS_BIT: begin
        next_rdata[15:0] = latch;
      end
      gpio_blk_pkg::OFS_FLAG: begin
        next_rdata[15:0] = flag;
      end
      gpio_blk_pkg::OFS_STAT: begin
        next_rdata[gpio_blk_pkg::STAT_OE_LO] = blk_oe[0];
        next_rdata[gpio_blk_pkg::STAT_OE_HI] = blk_oe[1];
        next_rdata[gpio_blk_pkg::STAT_ARM] = reset_arm;
        next_rdata[gpio_blk_pkg::STAT_STRAP] = strap_s;
        next_rdata[gpio_blk_pkg::STAT_INV_LO] = inv_s[0];
        next_rdata[gpio_blk_pkg::STAT_INV_HI] = inv_s[1];
      end
      default: begin
        next_rdata = gpio_blk_pkg::RST_RDATA;
      end
    endcase
  end

  // One-cycle ack; reads never touch enable state.
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= gpio_blk_pkg::RST_RDATA;
    end else begin
      o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
      if (rd) begin
        o_wb_dat <= next_rdata; // [RQ11] [RQ16]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  // A hardware reset aborts every property in flight, so none judges a half-done step.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_lo_byte_write;
    data_wr && i_wb_sel[0] && !strap_s;
  endsequence

  sequence s_sw_reset;
    sw_fire;
  endsequence

  sequence s_hi_byte_write;
    data_wr && i_wb_sel[1] && !strap_s;
  endsequence

  chk_block_wide_oe: assert property ( // [RQ8]
    (o_pin_oe[7:0] == '0 || o_pin_oe[7:0] == 8'hff) &&
    (o_pin_oe[15:8] == '0 || o_pin_oe[15:8] == 8'hff))
    else $error("Block enable is not all eight bits.");

  chk_idle_undriven: assert property ( // [RQ7]
    (o_pin_oe[7:0] != '0) |-> $past(blk_oe[0]))
    else $error("Low block drives while its enable was clear.");

  chk_noninv_map: assert property ( // [RQ3]
    s_lo_byte_write ##1 (!inv_s[0] && !sw_fire)
      |=> o_pin_out[7:0] == $past(i_wb_dat[7:0], 2) && o_pin_oe[7:0] == 8'hff)
    else $error("Non-inverted write did not reach the low pins.");

  chk_inv_map: assert property ( // [RQ5]
    s_lo_byte_write ##1 (inv_s[0] && !sw_fire)
      |=> o_pin_out[7:0] == ~$past(i_wb_dat[7:0], 2))
    else $error("Inverted write did not reach the low pins inverted.");

  chk_reset_level: assert property ( // [RQ2] [RQ4]
    s_sw_reset ##1 !(data_wr || bit_wr)
      |=> o_pin_out[7:0] == {8{$past(inv_s[0])}})
    else $error("Reset level of the low block is wrong.");

  chk_sw_reset_off: assert property ( // [RQ12]
    s_sw_reset |=> blk_oe == 2'b00 ##1 o_pin_oe == 16'h0000)
    else $error("Software reset did not return the port to input.");

  chk_oe_sticky: assert property ( // [RQ11]
    blk_oe[1] && !sw_fire |=> blk_oe[1])
    else $error("High block enable dropped without a reset.");

  chk_strap_input: assert property ( // [RQ15]
    strap_s |=> o_pin_oe == 16'h0000)
    else $error("Port drives while the output-disable strap is set.");

  chk_flag_cleared: assert property ( // [RQ14]
    s_sw_reset |=> !flag[gpio_blk_pkg::FLAG_SWRST_POS])
    else $error("Software reset left flag bit 15 set.");

  chk_bit_keeps: assert property ( // [RQ10]
    bit_wr && !sw_fire |=> (latch & ~(16'h0001 << $past(idx))) ==
      ($past(latch) & ~(16'h0001 << $past(idx))))
    else $error("Single-bit write disturbed other bits.");

  chk_echo_read: assert property ( // [RQ16]
    rd && i_wb_adr == gpio_blk_pkg::OFS_DATA |=> o_wb_dat[15:0] == $past(pin_s))
    else $error("Port read does not return the pin levels.");

  chk_ack_single: assert property (
    o_wb_ack |=> !o_wb_ack)
    else $error("Ack stood for more than one cycle.");

  chk_ack_answer: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("Request was not answered in the next cycle.");

  chk_lo_oe_sticky: assert property ( // [RQ11]
    blk_oe[0] && !sw_fire |=> blk_oe[0])
    else $error("Low block enable dropped without a reset.");

  chk_latch_holds: assert property ( // [RQ13]
    !(data_wr || bit_wr || sw_fire) |=> $stable(latch))
    else $error("Latch changed without a write or a reset.");

  chk_strap_no_enable: assert property ( // [RQ15]
    strap_s && blk_oe == 2'b00 |=> blk_oe == 2'b00)
    else $error("A block was enabled while the strap was set.");

  chk_hi_pin_map: assert property ( // [RQ3] [RQ5]
    s_hi_byte_write ##1 !sw_fire
      |=> o_pin_out[15:8] == ($past(i_wb_dat[15:8], 2) ^ {8{$past(inv_s[1])}}))
    else $error("High block write did not reach its pins.");

  chk_bit_enables: assert property ( // [RQ8]
    bit_wr && !strap_s |=> blk_oe[$past(idx[3])])
    else $error("Single-bit write did not enable its block.");

  chk_arm_cleared: assert property ( // [RQ12]
    s_sw_reset |=> !reset_arm)
    else $error("Software reset left the arm set.");

  chk_rdata_held: assert property ( // [RQ16]
    !rd |=> $stable(o_wb_dat))
    else $error("Read data changed without a read.");

endmodule : gpio_blk_ctrl

/* pin_load.sv */
// Board load model for the port pins: output drivers and shunt resistors.
// Assumes the block drives i_out wherever i_oe is high.
`timescale 1ns/100ps

module pin_load #(
  parameter logic PULL = 1'b1
) (
  // Drive from the block.
  input wire logic [15:0] i_out,
  input wire logic [15:0] i_oe,
  // Resolved pin levels.
  output logic [15:0] o_level
);
  // An undriven pin settles to the resistor level, so no stale value lingers.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      o_level[i] = i_oe[i] ? i_out[i] : PULL;
    end
  end
endmodule : pin_load

/* test_gpio_blk_ctrl.sv */
// Bench for gpio_blk_ctrl: Wishbone host cycles, pin loads and straps.
// Assumes the pin load model pulls every undriven pin high.
`timescale 1ns/100ps

module test_gpio_blk_ctrl;
  localparam logic [7:0] DAT = gpio_blk_pkg::OFS_DATA;
  localparam logic [7:0] BIT = gpio_blk_pkg::OFS_BIT;
  localparam logic [7:0] CTL = gpio_blk_pkg::OFS_CTRL;
  localparam logic [7:0] FLG = gpio_blk_pkg::OFS_FLAG;
  localparam logic [7:0] STA = gpio_blk_pkg::OFS_STAT;
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  logic strap = 1'b0;
  logic [1:0] inv = 2'b00;
  logic [15:0] lvl;
  logic [15:0] pout;
  logic [15:0] poe;
  int err_total = 0;
  int tests_run = 0;

  // A 40 ns period gives the 25 MHz reference clock.
  always #20 i_ref_clk = ~i_ref_clk;

  gpio_blk_ctrl u_dut (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_output_disable_strap(strap), .i_invert_sel(inv),
    .i_pin_in(lvl), .o_pin_out(pout), .o_pin_oe(poe)
  );
  pin_load u_load (.i_out(pout), .i_oe(poe), .o_level(lvl));

  ////////////////////////////////////////////////////////////////////////
  // Reporting.
  task automatic give_verdict;
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] s, input logic [31:0] e, input string m);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, m, s, e);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////
  // Bus and reset helpers; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      err_total++;
      $display("wrong value at %0t: no bus answer", $time);
      give_verdict();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // Three edges cover the pin register and the input synchroniser.
  task automatic settle;
    repeat (3) @(posedge i_ref_clk);
    #1;
  endtask : settle

  task automatic hw_reset(input logic [1:0] p);
    @(posedge i_ref_clk);
    i_arst_n <= 1'b0;
    inv <= p;
    repeat (20) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    settle();
    check(32'(poe), 32'h0000_0000, "oe after reset");
  endtask : hw_reset

  ////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_block;
    wb(1'b0, DAT, 4'hf, 32'h0);
    check(rd, 32'h0000_ffff, "idle pins");
    wb(1'b1, DAT, 4'h1, 32'h0000_00a5);
    settle();
    check(32'(poe), 32'h0000_00ff, "low block oe");
    check(32'(pout[7:0]), 32'h0000_00a5, "low drive");
    wb(1'b0, DAT, 4'hf, 32'h0);
    check(rd, 32'h0000_ffa5, "echo");
    $display("test block done");
  endtask : t_block

  task automatic t_bit;
    wb(1'b1, BIT, 4'hf, 32'h0000_0109);
    settle();
    check(32'(poe), 32'h0000_ffff, "high block oe");
    check(32'(pout), 32'h0000_02a5, "bit set");
    wb(1'b1, BIT, 4'hf, 32'h0000_0000);
    // The pin read lags the drive by the synchroniser, so let it settle first.
    settle();
    wb(1'b0, DAT, 4'hf, 32'h0);
    settle();
    check(rd, 32'h0000_02a4, "bit clear");
    check(32'(poe), 32'h0000_ffff, "oe after read");
    check(32'(pout), 32'h0000_02a4, "latched");
    $display("test bit done");
  endtask : t_bit

  task automatic t_swrst;
    wb(1'b1, FLG, 4'h3, 32'h0000_8001);
    wb(1'b1, CTL, 4'hf, 32'h0000_000f);
    settle();
    check(32'(poe), 32'h0000_ffff, "fire unarmed");
    wb(1'b1, CTL, 4'hf, 32'h0000_0100);
    wb(1'b1, CTL, 4'hf, 32'h0000_000f);
    settle();
    check(32'(poe), 32'h0000_0000, "soft reset oe");
    wb(1'b0, FLG, 4'h3, 32'h0);
    check(rd, 32'h0000_0001, "flag 15");
    $display("test soft reset done");
  endtask : t_swrst

  task automatic t_invert;
    hw_reset(2'b11);
    wb(1'b1, BIT, 4'hf, 32'h0000_0008);
    settle();
    check(32'(pout[15:8]), 32'h0000_00ff, "inverted reset");
    wb(1'b1, BIT, 4'hf, 32'h0000_0109);
    wb(1'b0, STA, 4'hf, 32'h0);
    check(rd, 32'h0000_0032, "status");
    settle();
    check(32'(pout[15:8]), 32'h0000_00fd, "inverted one");
    wb(1'b1, DAT, 4'h3, 32'h0000_040f);
    settle();
    check(32'(pout), 32'h0000_fbf0, "inverted word");
    check(32'(poe), 32'h0000_ffff, "both blocks oe");
    wb(1'b0, DAT, 4'hf, 32'h0);
    check(rd, 32'h0000_fbf0, "inverted echo");
    wb(1'b1, CTL, 4'hf, 32'h0000_0100);
    wb(1'b1, CTL, 4'hf, 32'h0000_000f);
    settle();
    check(32'(pout), 32'h0000_ffff, "inverted soft reset");
    check(32'(poe), 32'h0000_0000, "inverted reset oe");
    $display("test invert done");
  endtask : t_invert

  task automatic t_strap;
    hw_reset(2'b00);
    @(posedge i_ref_clk);
    strap <= 1'b1;
    settle();
    wb(1'b1, DAT, 4'h3, 32'h0000_ffff);
    settle();
    check(32'(poe), 32'h0000_0000, "strapped oe");
    wb(1'b0, 8'h20, 4'hf, 32'h0);
    check(rd, 32'h0, "unmapped read");
    $display("test strap done");
  endtask : t_strap

  // Main sequence.
  initial begin
    hw_reset(2'b00);
    t_block();
    t_bit();
    t_swrst();
    t_invert();
    t_strap();
    give_verdict();
  end
endmodule : test_gpio_blk_ctrl
